// ==== bst_test_registers.sv ====
`timescale 1ns/100ps
`default_nettype none

// Contract
// - One-bit bypass for BYPASS, CLAMP, HIGHZ.
// - Boundary chain with separate latched parallel stage.
// - Identification: 32-bit shifter plus latched output.
// - Identification selected by IDCODE or Test-Logic-Reset.
// - Identification never selected by other instructions.
// - ID fields: revision, part, maker, one.
// - ID loaded on rising edge in Capture-DR.
// - Test-Logic-Reset forces IDCODE into instruction output.
// - Three-bit instruction register selects data register.
module bst_test_registers (
    // Clock and reset.
    input  wire logic                           clock,
    input  wire logic                           rstn,
    // Scan pins.
    input  wire bst_pkg::bst_pins_in_type       scanIn,
    output bst_pkg::bst_pins_out_type           scanOut,
    // Boundary cells towards the device core.
    input  wire logic [bst_pkg::BSR_LEN-1:0]    bsCapture,
    output logic      [bst_pkg::BSR_LEN-1:0]    bsParallel,
    // Current state of the test logic.
    output logic      [bst_pkg::ID_LEN-1:0]     idParallel,
    output bst_pkg::bst_instr_type              curInstr,
    output bst_pkg::bst_sel_type                curSel,
    // Stream of bits leaving the data chain.
    output logic      [bst_pkg::STREAM_W-1:0]   streamData,
    output logic                                streamValid,
    input  wire logic                           streamReady
);
    import bst_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and scan clock edge detection.

    logic [1:0]          clkSync;
    logic [1:0]          tmsSync;
    logic [1:0]          tdiSync;
    logic                clkPrev;
    logic                risePend;
    logic                fallPend;
    logic                riseSeen;
    logic                fallSeen;
    logic                doRise;
    logic                doFall;
    logic                bufReady;
    logic                tms;
    logic                tdi;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            clkSync <= 2'h0;
            tmsSync <= 2'h0;
            tdiSync <= 2'h0;
            clkPrev <= 1'b0;
        end else begin
            clkSync <= {clkSync[0], scanIn.scanClock};
            tmsSync <= {tmsSync[0], scanIn.scanModeSelect};
            tdiSync <= {tdiSync[0], scanIn.scanSerialIn};
            clkPrev <= clkSync[1];
        end
    end

    assign tms      = tmsSync[1];
    assign tdi      = tdiSync[1];
    assign riseSeen = clkSync[1] && !clkPrev;
    assign fallSeen = !clkSync[1] && clkPrev;
    // A full buffer holds back one pending rise and one pending fall, so a receiver that stalls for less than one scan period loses no bit.
    assign doRise   = (riseSeen || risePend) && bufReady;
    assign doFall   = (fallSeen || fallPend) && bufReady && !(riseSeen || risePend);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            risePend <= 1'b0;
            fallPend <= 1'b0;
        end else begin
            risePend <= (riseSeen || risePend) && !doRise;
            fallPend <= (fallSeen || fallPend) && !doFall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller state.

    bst_tap_type state_reg;
    bst_tap_type state_next;

    always_comb begin
        unique case (state_reg)
            TAP_RESET:      state_next = tms ? TAP_RESET     : TAP_IDLE;
            TAP_IDLE:       state_next = tms ? TAP_SEL_DR    : TAP_IDLE;
            TAP_SEL_DR:     state_next = tms ? TAP_SEL_IR    : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: state_next = tms ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
            TAP_SHIFT_DR:   state_next = tms ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
            TAP_EXIT1_DR:   state_next = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR:   state_next = tms ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
            TAP_EXIT2_DR:   state_next = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR:  state_next = tms ? TAP_SEL_DR    : TAP_IDLE;
            TAP_SEL_IR:     state_next = tms ? TAP_RESET     : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: state_next = tms ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
            TAP_SHIFT_IR:   state_next = tms ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
            TAP_EXIT1_IR:   state_next = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR:   state_next = tms ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
            TAP_EXIT2_IR:   state_next = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR:  state_next = tms ? TAP_SEL_DR    : TAP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= TAP_RESET;
        end else if (doRise) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register and register selection.

    bst_instr_type irShift_reg;
    bst_sel_type   selNow;

    always_comb begin
        if (state_reg == TAP_RESET) begin
            selNow = SEL_ID;
        end else begin
            unique case (curInstr)
                INS_IDCODE:             selNow = SEL_ID;
                INS_EXTEST, INS_SAMPLE: selNow = SEL_BOUNDARY;
                default:                selNow = SEL_BYPASS;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irShift_reg <= IR_CAPTURE;
            curInstr    <= INS_IDCODE;
            curSel      <= SEL_ID;
        end else begin
            curSel <= selNow;
            if (doRise && state_reg == TAP_CAPTURE_IR) begin
                irShift_reg <= IR_CAPTURE;
            end else if (doRise && state_reg == TAP_SHIFT_IR) begin
                irShift_reg <= {tdi, irShift_reg[IR_LEN-1:1]};
            end
            if (state_reg == TAP_RESET) begin
                curInstr <= INS_IDCODE;
            end else if (doFall && state_reg == TAP_UPDATE_IR) begin
                curInstr <= irShift_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data registers.

    logic                bypass_reg;
    logic [BSR_LEN-1:0]  bsShift_reg;
    logic [ID_LEN-1:0]   idShift_reg;
    logic                leaving;

    always_comb begin
        unique case (selNow)
            SEL_ID:       leaving = idShift_reg[0];
            SEL_BOUNDARY: leaving = bsShift_reg[0];
            default:      leaving = bypass_reg;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bypass_reg <= BYPASS_CAPTURE;
        end else if (doRise && selNow == SEL_BYPASS) begin
            if (state_reg == TAP_CAPTURE_DR) begin
                bypass_reg <= BYPASS_CAPTURE;
            end else if (state_reg == TAP_SHIFT_DR) begin
                bypass_reg <= tdi;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bsShift_reg <= '0;
            bsParallel  <= '0;
        end else begin
            if (doRise && selNow == SEL_BOUNDARY && state_reg == TAP_CAPTURE_DR) begin
                bsShift_reg <= bsCapture;
            end else if (doRise && selNow == SEL_BOUNDARY && state_reg == TAP_SHIFT_DR) begin
                bsShift_reg <= {tdi, bsShift_reg[BSR_LEN-1:1]};
            end
            if (doFall && selNow == SEL_BOUNDARY && state_reg == TAP_UPDATE_DR) begin
                bsParallel <= bsShift_reg;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            idShift_reg <= ID_VALUE;
            idParallel  <= ID_VALUE;
        end else begin
            if (doRise && selNow == SEL_ID && state_reg == TAP_CAPTURE_DR) begin
                idShift_reg <= ID_VALUE;
            end else if (doRise && selNow == SEL_ID && state_reg == TAP_SHIFT_DR) begin
                idShift_reg <= {tdi, idShift_reg[ID_LEN-1:1]};
            end
            if (doFall && selNow == SEL_ID && state_reg == TAP_UPDATE_DR) begin
                idParallel <= idShift_reg;
            end
        end
    end

    // The serial output changes on the falling scan edge and drives only while shifting.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            scanOut <= '0;
        end else if (doFall) begin
            scanOut.scanSerialOut   <= (state_reg == TAP_SHIFT_IR) ? irShift_reg[0] : leaving;
            scanOut.scanSerialOutEn <= (state_reg == TAP_SHIFT_IR) || (state_reg == TAP_SHIFT_DR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream buffer for bits leaving the data chain.

    bst_skid_buffer #(
        .WIDTH (STREAM_W),
        .DEPTH (BUF_DEPTH)
    ) uBuffer (
        .clock    (clock),
        .rstn     (rstn),
        .inData   (STREAM_W'(leaving)),
        .inValid  (doRise && state_reg == TAP_SHIFT_DR),
        .inReady  (bufReady),
        .outData  (streamData),
        .outValid (streamValid),
        .outReady (streamReady)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_bypass_one_stage: assert property (doRise && state_reg == TAP_SHIFT_DR && selNow == SEL_BYPASS
        |=> bypass_reg == $past(tdi)) else $error("bypass stage did not take serial input");
    chk_bsr_latch: assert property (doFall && state_reg == TAP_UPDATE_DR && selNow == SEL_BOUNDARY
        |=> bsParallel == $past(bsShift_reg)) else $error("boundary parallel stage not latched");
    chk_bsr_hold: assert property (!(doFall && state_reg == TAP_UPDATE_DR)
        |=> $stable(bsParallel)) else $error("boundary parallel stage moved outside update");
    chk_id_latch: assert property (doFall && state_reg == TAP_UPDATE_DR && selNow == SEL_ID
        |=> idParallel == $past(idShift_reg)) else $error("identification output not latched");
    chk_tlr_select: assert property (state_reg == TAP_RESET [*2]
        |-> curSel == SEL_ID) else $error("identification not selected in reset state");
    chk_id_exclusive: assert property (state_reg != TAP_RESET && curInstr != INS_IDCODE
        |-> selNow != SEL_ID) else $error("identification selected by foreign instruction");
    chk_id_fields: assert property (doRise && state_reg == TAP_CAPTURE_DR && selNow == SEL_ID
        |=> idShift_reg[0] == 1'b1 && idShift_reg[11:1] == ID_MAKER && idShift_reg[27:12] == ID_PART)
        else $error("identification fields wrong");
    chk_id_capture: assert property (doRise && state_reg == TAP_CAPTURE_DR && curInstr == INS_IDCODE
        |=> idShift_reg == ID_VALUE) else $error("identification code not captured");
    chk_tlr_force: assert property (state_reg == TAP_RESET
        |=> curInstr == INS_IDCODE) else $error("reset state did not force identification");
    chk_ir_decode: assert property (state_reg != TAP_RESET && curInstr == INS_EXTEST
        |-> selNow == SEL_BOUNDARY) else $error("instruction decode wrong");
    chk_shift_lsb: assert property (doRise && state_reg == TAP_SHIFT_DR && selNow == SEL_ID
        |=> idShift_reg == {$past(tdi), $past(idShift_reg[ID_LEN-1:1])}) else $error("shift not toward bit zero");

    cov_id_read: cover property (state_reg == TAP_CAPTURE_DR && curInstr == INS_IDCODE
        ##[1:200] state_reg == TAP_SHIFT_DR);
    cov_ir_load: cover property (doFall && state_reg == TAP_UPDATE_IR);
    cov_bsr_update: cover property (doFall && state_reg == TAP_UPDATE_DR && selNow == SEL_BOUNDARY);
    cov_stall: cover property (!bufReady ##1 risePend);

endmodule : bst_test_registers

`default_nettype wire

// ==== bst_pkg.sv ====
package bst_pkg;

    localparam int ID_LEN    = 32;
    localparam int IR_LEN    = 3;
    localparam int BSR_LEN   = 8;
    localparam int STREAM_W  = 1;
    localparam int BUF_DEPTH = 2;

    typedef logic [IR_LEN-1:0] bst_instr_type;

    localparam bst_instr_type INS_EXTEST = 3'h0;
    localparam bst_instr_type INS_IDCODE = 3'h1;
    localparam bst_instr_type INS_SAMPLE = 3'h2;
    localparam bst_instr_type INS_CLAMP  = 3'h3;
    localparam bst_instr_type INS_HIGHZ  = 3'h4;
    localparam bst_instr_type INS_BYPASS = 3'h7;

    // Fixed value loaded into the instruction shifter in Capture-IR.
    localparam bst_instr_type IR_CAPTURE = 3'h1;

    // Identification fields; the revision, part and maker values are arbitrary.
    localparam logic [3:0]  ID_REVISION = 4'h0;
    localparam logic [15:0] ID_PART     = 16'h5A5A;
    localparam logic [10:0] ID_MAKER    = 11'h155;
    localparam logic        ID_REQUIRED = 1'b1;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_MAKER, ID_REQUIRED};

    localparam logic BYPASS_CAPTURE = 1'b0;

    typedef enum logic [1:0] {
        SEL_BYPASS   = 2'b00,
        SEL_BOUNDARY = 2'b01,
        SEL_ID       = 2'b10
    } bst_sel_type;

    typedef enum logic [3:0] {
        TAP_RESET      = 4'b0000,
        TAP_IDLE       = 4'b0001,
        TAP_SEL_DR     = 4'b0010,
        TAP_CAPTURE_DR = 4'b0011,
        TAP_SHIFT_DR   = 4'b0100,
        TAP_EXIT1_DR   = 4'b0101,
        TAP_PAUSE_DR   = 4'b0110,
        TAP_EXIT2_DR   = 4'b0111,
        TAP_UPDATE_DR  = 4'b1000,
        TAP_SEL_IR     = 4'b1001,
        TAP_CAPTURE_IR = 4'b1010,
        TAP_SHIFT_IR   = 4'b1011,
        TAP_EXIT1_IR   = 4'b1100,
        TAP_PAUSE_IR   = 4'b1101,
        TAP_EXIT2_IR   = 4'b1110,
        TAP_UPDATE_IR  = 4'b1111
    } bst_tap_type;

    typedef struct packed {
        logic scanClock;
        logic scanModeSelect;
        logic scanSerialIn;
    } bst_pins_in_type;

    typedef struct packed {
        logic scanSerialOut;
        logic scanSerialOutEn;
    } bst_pins_out_type;

endpackage : bst_pkg

// ==== bst_skid_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none

// Shifting buffer: entry 0 is always the head, so the outputs come from flops.
module bst_skid_buffer #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rstn,
    // Filling side.
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Draining side.
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);

    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] memReg [DEPTH];
    logic [DEPTH-1:0] vldReg;
    logic [CW-1:0]    countReg;
    logic [CW-1:0]    countNext;
    logic [CW-1:0]    slot;
    logic             push;
    logic             pop;

    assign inReady   = (countReg != CW'(DEPTH));
    assign push      = inValid && inReady;
    assign pop       = vldReg[0] && outReady;
    assign slot      = countReg - CW'(pop);
    assign countNext = countReg + CW'(push) - CW'(pop);
    assign outData   = memReg[0];
    assign outValid  = vldReg[0];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            countReg <= '0;
        end else begin
            countReg <= countNext;
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
        always_ff @(posedge clock) begin
            if (!rstn) begin
                vldReg[i] <= 1'b0;
                memReg[i] <= '0;
            end else begin
                vldReg[i] <= (CW'(i) < countNext);
                if (push && slot == CW'(i)) begin
                    memReg[i] <= inData;
                end else if (pop && i + 1 < DEPTH) begin
                    memReg[i] <= memReg[(i + 1 < DEPTH) ? i + 1 : i];
                end
            end
        end
    end

endmodule : bst_skid_buffer

`default_nettype wire

// ==== bst_scan_tester.sv ====
`timescale 1ns/100ps
`default_nettype none

// Tester side of the scan link; the scan clock rests low between frames and the data line idles high.
module bst_scan_tester (
    // Clock that paces the scan edges.
    input  wire logic                      clock,
    // Scan pins.
    output var bst_pkg::bst_pins_in_type   pins,
    input  wire bst_pkg::bst_pins_out_type outs
);
    import bst_pkg::*;

    // Four system clocks per half period give the 160 ns scan period.
    localparam int HALF = 4;

    initial pins = 3'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode and data are set while the clock is low; the output is sampled while it is high.
    task automatic pulse(input logic tms, input logic tdi, output logic tdo);
        @(posedge clock);
        #1;
        pins.scanModeSelect = tms;
        pins.scanSerialIn   = tdi;
        repeat (HALF - 1) @(posedge clock);
        #1;
        pins.scanClock = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        // A released data line floats to its pull-up level.
        tdo = outs.scanSerialOutEn ? outs.scanSerialOut : 1'b1;
        repeat (HALF - 2) @(posedge clock);
        #1;
        pins.scanClock = 1'b0;
    endtask : pulse

    task automatic tap_reset();
        logic d;
        repeat (5) pulse(1'b1, 1'b1, d);
        pulse(1'b0, 1'b1, d);
    endtask : tap_reset

    task automatic scan_ir(input bst_instr_type code, output bst_instr_type cap);
        logic d;
        pulse(1'b1, 1'b1, d);
        pulse(1'b1, 1'b1, d);
        pulse(1'b0, 1'b1, d);
        pulse(1'b0, 1'b1, d);
        for (int i = 0; i < IR_LEN; i++) pulse(i == IR_LEN - 1, code[i], cap[i]);
        pulse(1'b1, 1'b1, d);
        pulse(1'b0, 1'b1, d);
    endtask : scan_ir

    // From Idle through Capture-DR into Shift-DR.
    task automatic enter_dr();
        logic d;
        pulse(1'b1, 1'b1, d);
        pulse(1'b0, 1'b1, d);
        pulse(1'b0, 1'b1, d);
    endtask : enter_dr

    // From Exit1-DR through Update-DR back to Idle.
    task automatic leave_dr();
        logic d;
        pulse(1'b1, 1'b1, d);
        pulse(1'b0, 1'b1, d);
    endtask : leave_dr

    task automatic scan_dr(input int len, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        enter_dr();
        for (int i = 0; i < len; i++) pulse(i == len - 1, din[i], dout[i]);
        leave_dr();
    endtask : scan_dr

endmodule : bst_scan_tester

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
    import bst_pkg::*;

    localparam int          LIMIT  = 20000;
    localparam logic [31:0] EXP_ID = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};

    logic                clock;
    logic                rstn;
    bst_pins_in_type     scanIn;
    bst_pins_out_type    scanOut;
    logic [BSR_LEN-1:0]  bsCapture;
    logic [BSR_LEN-1:0]  bsParallel;
    logic [ID_LEN-1:0]   idParallel;
    bst_instr_type       curInstr;
    bst_sel_type         curSel;
    logic [STREAM_W-1:0] streamData;
    logic                streamValid;
    logic                streamReady;
    logic                streamQ[$];
    int                  errCount;
    int                  cmpCount;
    int                  cycles;

    bst_test_registers i_bst_test_registers (
        .clock       (clock),
        .rstn        (rstn),
        .scanIn      (scanIn),
        .scanOut     (scanOut),
        .bsCapture   (bsCapture),
        .bsParallel  (bsParallel),
        .idParallel  (idParallel),
        .curInstr    (curInstr),
        .curSel      (curSel),
        .streamData  (streamData),
        .streamValid (streamValid),
        .streamReady (streamReady)
    );

    bst_scan_tester i_bst_scan_tester (
        .clock (clock),
        .pins  (scanIn),
        .outs  (scanOut)
    );

    always #10 clock = ~clock;

    // Collects every bit the receiver accepts and cuts a hang short.
    always @(posedge clock) begin
        if (rstn && streamValid === 1'b1 && streamReady) streamQ.push_back(streamData[0]);
        cycles++;
        if (cycles == LIMIT) begin
            errCount++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check_queue(input int len, input logic [31:0] exp);
        logic [31:0] st;
        st = '0;
        foreach (streamQ[i]) st[i] = streamQ[i];
        check(32'(streamQ.size()), 32'(len));
        check(st, exp);
        streamQ.delete();
    endtask : check_queue

    task automatic dr(input int len, input logic [31:0] din, input logic [31:0] exp);
        logic [31:0] got;
        streamQ.delete();
        i_bst_scan_tester.scan_dr(len, din, got);
        check(got, exp);
        check_queue(len, exp);
    endtask : dr

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_id();
        check(idParallel, EXP_ID);
        check(32'(curInstr), 32'(INS_IDCODE));
        check(32'(curSel), 32'(SEL_ID));
        check(32'(scanOut.scanSerialOutEn), 32'h0);
        i_bst_scan_tester.tap_reset();
        dr(ID_LEN, 32'h1234_5679, EXP_ID);
        check(idParallel, 32'h1234_5679);
        dr(ID_LEN, 32'h0, EXP_ID);
        $display("test_id done, mismatches %0d", errCount);
    endtask : test_id

    task automatic test_instr();
        bst_instr_type cap;
        bst_sel_type   want;
        logic [7:0]    keep;
        for (int c = 0; c < 8; c++) begin
            want = (c == 0 || c == 2) ? SEL_BOUNDARY : (c == 1) ? SEL_ID : SEL_BYPASS;
            @(posedge clock);
            #1;
            bsCapture = 8'hC3 ^ 8'(c);
            keep = bsParallel;
            i_bst_scan_tester.scan_ir(3'(c), cap);
            check(32'(cap), 32'(IR_CAPTURE));
            check(32'(curInstr), 32'(c));
            check(32'(curSel), 32'(want));
            if (want == SEL_BOUNDARY) begin
                dr(BSR_LEN, 32'h5A ^ 32'(c), 32'hC3 ^ 32'(c));
                check(32'(bsParallel), 32'h5A ^ 32'(c));
            end else if (want == SEL_BYPASS) begin
                dr(4, 32'hA, 32'h4);
                check(32'(bsParallel), 32'(keep));
            end else begin
                dr(ID_LEN, 32'h0, EXP_ID);
            end
        end
        $display("test_instr done, mismatches %0d", errCount);
    endtask : test_instr

    // The receiver stalls from the start; once two bits fill the buffer, the held scan edge must lose nothing.
    task automatic test_stall();
        logic d;
        i_bst_scan_tester.tap_reset();
        check(32'(curInstr), 32'(INS_IDCODE));
        check(32'(curSel), 32'(SEL_ID));
        streamQ.delete();
        @(posedge clock);
        #1;
        streamReady = 1'b0;
        i_bst_scan_tester.enter_dr();
        for (int i = 0; i < ID_LEN; i++) begin
            if (i == 2) begin
                repeat (10) @(posedge clock);
                #1;
                check(32'(streamValid), 32'h1);
                check(32'(streamData), 32'(EXP_ID[0]));
            end
            i_bst_scan_tester.pulse(i == ID_LEN - 1, 1'b1, d);
            if (i == 2) begin
                streamReady = 1'b1;
                repeat (8) @(posedge clock);
            end
        end
        i_bst_scan_tester.leave_dr();
        check_queue(ID_LEN, EXP_ID);
        $display("test_stall done, mismatches %0d", errCount);
    endtask : test_stall

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        streamReady = 1'b1;
        bsCapture = 8'h00;
        errCount = 0;
        cmpCount = 0;
        cycles = 0;
        repeat (8) @(posedge clock);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge clock);
        test_id();
        test_instr();
        test_stall();
        summarize();
    end

endmodule : tb

`default_nettype wire
